//--- common/afx_pkg.sv
/*
  Package for the external FIFO host controller: pin groups, timing figures
  and cycle counts. Assumes a 100 MHz controller clock.
*/
package afx_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Timing figures (ns) of the fastest grade
  // ----------------------------------------------------------------
  localparam int T_PULSE_NS = 35;   // strobe low time
  localparam int T_RECOV_NS = 10;   // strobe high time
  localparam int T_ACCESS_NS = 25;  // strobe low to data valid
  localparam int T_RST_NS = 35;     // clear pulse width
  localparam int T_RSC_NS = 45;     // clear or replay cycle until flags valid
  localparam int T_RSS_NS = 30;     // strobes high before clear release
  localparam int T_RSR_NS = 15;     // strobes high after clear release
  localparam int T_FLAG_NS = 35;    // strobe edge to flag settle

  // Least times round up
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CYC = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSC_CYC = (T_RSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSS_CYC = (T_RSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSR_CYC = (T_RSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_CYC = (T_FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 4;
  localparam int DATA_W = 9;

  // Flags from the device, all active low
  typedef struct packed {
    logic empty_indicator_n;
    logic full_indicator_n;
    logic half_level_indicator_n;
  } afx_flags_s;

  // Control pins toward the device, all active low
  typedef struct packed {
    logic clear_pin_n;
    logic replay_pin_n;
    logic store_n;
    logic fetch_n;
  } afx_ctrl_s;

  typedef enum logic [2:0] {
    ST_CLEAR  = 3'b000,
    ST_SETTLE = 3'b001,
    ST_IDLE   = 3'b010,
    ST_WLOW   = 3'b011,
    ST_RLOW   = 3'b100,
    ST_RECOV  = 3'b101,
    ST_REPLAY = 3'b110
  } afx_state_e;

endpackage

//--- core/afx_host.sv
/*
  Host controller that drives an external clockless 9-bit FIFO: clear,
  store and fetch strobes, replay pulse, flag sampling.
  Assumes flag and data inputs are already synchronous to clk.
*/
// Behaviour
// R01 - Fetch only starts while not empty
// R02 - Reads return words in write order
// R03 - Data bus floats after fetch strobe rises
// R04 - No fetch issued once device empty
// R05 - Empty released after write completes
// R06 - Empty rechecked before every fetch
// R07 - Fetch near empty release is avoided
// R08 - Clear pin low resets both pointers
// R09 - Clear always applied before any write
// R10 - Flags ignored until clear cycle ends
// R11 - Replay pulse rewinds read pointer
// R12 - Flags ignored until replay cycle ends
// R13 - Replay refused in depth expansion
// R14 - Chain-in grounded at clear: single mode
// R15 - Width grows by paralleling devices
// R16 - Width mode flags from one device
// R17 - Half flag same in width mode
// R18 - Never tie device flags together
// R19 - Half flag falls on next store
// R20 - Half flag rises on fetch strobe rise
// R21 - Depth mode flags combined outside
// R22 - Pointers wrap, status by distance
// R23 - Store only starts while not full
// R24 - No store issued once device full
// R25 - First device select grounded once
// R26 - Reads and writes independent
`timescale 1ns/1ps
`default_nettype none
module afx_host
  import afx_pkg::*;
#(
  parameter int DATA_W_P = DATA_W,
  parameter bit DEPTH_MODE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic init_req,
  input wire logic wr_req,
  input wire logic [DATA_W_P-1:0] wr_data,
  input wire logic rd_req,
  input wire logic replay_req,
  output logic busy,
  output logic wr_done,
  output logic wr_refused,
  output logic rd_valid,
  output logic [DATA_W_P-1:0] rd_data,
  output logic rd_refused,
  output logic replay_refused,
  output logic flags_valid,
  output logic half_level,
  input wire afx_flags_s dev_flags,
  output afx_ctrl_s dev_ctrl,
  output logic chain_in_n,
  output logic first_chain_select_n,
  output logic [DATA_W_P-1:0] dev_din,
  input wire logic [DATA_W_P-1:0] dev_dout
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  afx_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] settle;
  logic rd_pend;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // One flag set, from one device or from outside combining logic;
  // flags are never wired together here; see R16 see R18 see R21
  wire logic cnt_zero = (cnt == '0);
  wire logic idle = (state == ST_IDLE);
  // Flags only trusted in idle after their settle time; see R10 see R12
  wire logic flag_ok = idle && (settle == '0);
  wire logic can_rd = flag_ok && dev_flags.empty_indicator_n;  // see R01 see R06
  // No pointer copy kept: device status is distance based; see R22
  wire logic can_wr = flag_ok && dev_flags.full_indicator_n;   // see R23
  wire logic go_init = idle && init_req;
  wire logic go_replay = idle && !init_req && replay_req && !DEPTH_MODE;  // see R13
  wire logic go_wr = idle && !init_req && !replay_req && wr_req && can_wr;
  // Write wins a tie; fetch is not queued and needs rd_req again once flags settle
  wire logic go_rd = idle && !init_req && !replay_req && !wr_req && rd_req && can_rd;
  wire logic rd_end = (state == ST_RLOW) && cnt_zero;
  wire logic clear_low = (state == ST_CLEAR) && (cnt >= CNT_W'(RSS_CYC));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt_zero ? cnt : cnt - CNT_W'(1);
    unique case (state)
      ST_CLEAR: begin
        // Strobes stay high before, during and after clear; see R09
        if (cnt_zero) begin
          next_state = ST_SETTLE;
          next_cnt = CNT_W'(RSR_CYC);
        end
      end
      ST_SETTLE: begin
        if (cnt_zero) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (go_init) begin
          next_state = ST_CLEAR;
          next_cnt = CNT_W'(RSS_CYC + RST_CYC);
        end else if (go_replay) begin
          // Counts down a full pulse: one cycle wider than a strobe
          next_state = ST_REPLAY;
          next_cnt = CNT_W'(PULSE_CYC);
        end else if (go_wr) begin
          next_state = ST_WLOW;
          next_cnt = CNT_W'(PULSE_CYC - 1);
        end else if (go_rd) begin
          next_state = ST_RLOW;
          next_cnt = CNT_W'(PULSE_CYC - 1);
        end
      end
      ST_WLOW, ST_RLOW: begin
        if (cnt_zero) begin
          next_state = ST_RECOV;
          next_cnt = CNT_W'(RECOV_CYC - 1);
        end
      end
      ST_RECOV, ST_REPLAY: begin
        if (cnt_zero) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_CLEAR;
        next_cnt = CNT_W'(RSS_CYC + RST_CYC);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_CLEAR;
      cnt <= CNT_W'(RSS_CYC + RST_CYC);
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Settle window after clear, replay or any strobe; see R05 see R07
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle <= CNT_W'(RSC_CYC);
    end else if (state == ST_CLEAR || state == ST_REPLAY) begin
      settle <= CNT_W'(RSC_CYC);
    end else if (state == ST_WLOW || state == ST_RLOW) begin
      settle <= CNT_W'(FLAG_CYC);
    end else if (settle != '0) begin
      settle <= settle - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_ctrl <= '{clear_pin_n: 1'b0, replay_pin_n: 1'b1, store_n: 1'b1, fetch_n: 1'b1};
      dev_din <= '0;
      busy <= 1'b1;
      wr_done <= 1'b0;
      wr_refused <= 1'b0;
      rd_refused <= 1'b0;
      replay_refused <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      rd_pend <= 1'b0;
      flags_valid <= 1'b0;
      half_level <= 1'b0;
      chain_in_n <= DEPTH_MODE;
      first_chain_select_n <= 1'b0;
    end else begin
      dev_ctrl.clear_pin_n <= !clear_low;                            // see R08
      dev_ctrl.store_n <= !(go_wr || (state == ST_WLOW && !cnt_zero));  // see R26
      dev_ctrl.fetch_n <= !(go_rd || (state == ST_RLOW && !cnt_zero));  // see R03
      dev_ctrl.replay_pin_n <= !(go_replay || (state == ST_REPLAY && !cnt_zero));  // see R11
      if (go_wr) begin
        // Bus width follows the devices set side by side
        dev_din <= wr_data;  // see R15
      end
      busy <= !(next_state == ST_IDLE);
      wr_done <= (state == ST_WLOW) && cnt_zero;
      wr_refused <= idle && !init_req && !replay_req && wr_req && !can_wr;  // see R24
      rd_refused <= idle && !init_req && !replay_req && !wr_req && rd_req
                    && !can_rd;                                         // see R04
      replay_refused <= idle && !init_req && replay_req && DEPTH_MODE;
      rd_pend <= go_rd ? 1'b1 : (rd_end ? 1'b0 : rd_pend);
      // Sample data just before strobe rises; access time fits the pulse
      rd_valid <= rd_end && rd_pend;                                    // see R02
      if (rd_end) begin
        rd_data <= dev_dout;
      end
      flags_valid <= flag_ok;
      if (flag_ok) begin
        half_level <= !dev_flags.half_level_indicator_n;  // see R19 see R20 see R17
      end
      // Mode straps: chain-in grounded selects single mode; see R14
      chain_in_n <= DEPTH_MODE;
      first_chain_select_n <= 1'b0;  // see R25
    end
  end

endmodule
`default_nettype wire

//--- dv/afx_host_properties.sv
/*
  Port checker for afx_host, bound to it below.
  Assumes one clock domain and the flags and data already synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module afx_host_properties
  import afx_pkg::*;
#(
  parameter int DATA_W_P = DATA_W,
  parameter bit DEPTH_MODE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_done,
  input wire logic rd_valid,
  input wire logic [DATA_W_P-1:0] rd_data,
  input wire logic wr_refused,
  input wire logic rd_refused,
  input wire logic replay_refused,
  input wire logic flags_valid,
  input wire afx_flags_s dev_flags,
  input wire afx_ctrl_s dev_ctrl,
  input wire logic chain_in_n,
  input wire logic first_chain_select_n,
  input wire logic [DATA_W_P-1:0] dev_dout
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_fetch_gate: assert property ($fell(dev_ctrl.fetch_n) |-> $past(dev_flags.empty_indicator_n))
    else $error("fetch started while empty");
  chk_store_gate: assert property ($fell(dev_ctrl.store_n) |-> $past(dev_flags.full_indicator_n))
    else $error("store started while full");
  chk_fetch_release: assert property ($fell(dev_ctrl.fetch_n) |=> !dev_ctrl.fetch_n [*3] ##1 dev_ctrl.fetch_n)
    else $error("fetch strobe width wrong");
  chk_read_answer: assert property ($fell(dev_ctrl.fetch_n) |-> ##4 rd_valid)
    else $error("read answer late");
  chk_read_data: assert property (rd_valid |-> rd_data == $past(dev_dout))
    else $error("read word not captured");
  chk_write_done: assert property ($fell(dev_ctrl.store_n) |-> ##4 wr_done)
    else $error("write done late");
  chk_clear_quiet: assert property (!dev_ctrl.clear_pin_n |-> dev_ctrl.store_n && dev_ctrl.fetch_n)
    else $error("strobe low during clear");
  chk_clear_settle: assert property ($rose(dev_ctrl.clear_pin_n) |-> !flags_valid [*2])
    else $error("flags trusted during clear cycle");
  chk_replay_pulse: assert property ($fell(dev_ctrl.replay_pin_n) |=> !dev_ctrl.replay_pin_n [*4] ##1 dev_ctrl.replay_pin_n)
    else $error("replay pulse width wrong");
  chk_replay_depth: assert property (DEPTH_MODE |-> dev_ctrl.replay_pin_n)
    else $error("replay in depth mode");
  chk_refuse_depth: assert property (replay_refused |-> DEPTH_MODE)
    else $error("replay refused in single mode");
  chk_mode_strap: assert property (chain_in_n == DEPTH_MODE && !first_chain_select_n)
    else $error("mode straps wrong");
  cover property (rd_valid);
  cover property (wr_refused);
  cover property (rd_refused);
  cover property ($fell(dev_ctrl.replay_pin_n));
  cover property (replay_refused);
endmodule
bind afx_host afx_host_properties #(.DATA_W_P(DATA_W_P), .DEPTH_MODE(DEPTH_MODE)) u_chk (.*);
`default_nettype wire

//--- dv/afx_fifo_model.sv
/*
  Behavioural clockless FIFO device, the far side of afx_host.
  Assumes strobes are clean and pulse widths are kept by the host.
*/
`timescale 1ns/1ps
`default_nettype none
module afx_fifo_model
  import afx_pkg::*;
#(
  parameter int DEPTH_P = 8
) (
  input wire afx_ctrl_s ctrl,
  input wire logic chain_in_n,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout,
  output afx_flags_s flags
);
  logic [DATA_W-1:0] mem [DEPTH_P];
  int wp = 0;
  int rp = 0;
  bit rok = 1'b0;
  bit wok = 1'b0;
  bit single = 1'b1;
  initial dout = 9'h0A5;
  // Status from pointer distance only, so wrap is invisible
  assign flags = '{wp != rp, wp - rp != DEPTH_P, wp - rp <= DEPTH_P / 2};
  always @(negedge ctrl.clear_pin_n) begin
    wp = 0;
    rp = 0;
    single = !chain_in_n;
  end
  always @(negedge ctrl.replay_pin_n) if (single) rp = 0;
  always @(negedge ctrl.store_n) wok = flags.full_indicator_n;
  always @(posedge ctrl.store_n) if (wok) begin
    mem[wp % DEPTH_P] = din;
    wp++;
  end
  always @(negedge ctrl.fetch_n) begin
    rok = flags.empty_indicator_n;
    if (rok) dout = mem[rp % DEPTH_P];
  end
  // Released bus shows the inverse, never a stale word
  always @(posedge ctrl.fetch_n) if (rok) begin
    rp++;
    dout = ~dout;
  end
endmodule
`default_nettype wire

//--- dv/afx_host_tb.sv
/*
  Self-checking bench for afx_host against the device model.
  Assumes a depth of 8 words in the model to reach full quickly.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module afx_host_tb
  import afx_pkg::*;
;
  localparam int DEPTH = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic init_req = 1'b0, wr_req = 1'b0, rd_req = 1'b0, replay_req = 1'b0;
  logic [DATA_W-1:0] wr_data = 9'h000, rd_data, dev_din, dev_dout;
  logic busy, wr_done, wr_refused, rd_valid, rd_refused, replay_refused, flags_valid;
  logic half_level, chain_in_n, first_chain_select_n;
  logic [3:0] seen;
  afx_flags_s dev_flags;
  afx_ctrl_s dev_ctrl;
  // Second host strapped for depth expansion, own device model
  logic [DATA_W-1:0] dp_dev_din, dp_dev_dout;
  logic dp_replay_refused, dp_chain_in_n;
  afx_flags_s dp_dev_flags;
  afx_ctrl_s dp_dev_ctrl;
  logic [1:0] rpl_ref = 2'b00;
  int n_mismatch = 0, samples_checked = 0;
  afx_host u_afx_host (.clk(clk), .rst(rst), .init_req(init_req), .wr_req(wr_req),
    .wr_data(wr_data), .rd_req(rd_req), .replay_req(replay_req), .busy(busy),
    .wr_done(wr_done), .wr_refused(wr_refused), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_refused(rd_refused), .replay_refused(replay_refused), .flags_valid(flags_valid),
    .half_level(half_level), .dev_flags(dev_flags), .dev_ctrl(dev_ctrl),
    .chain_in_n(chain_in_n), .first_chain_select_n(first_chain_select_n),
    .dev_din(dev_din), .dev_dout(dev_dout));
  afx_host #(.DEPTH_MODE(1'b1)) u_afx_host_depth (.clk(clk), .rst(rst), .init_req(init_req),
    .wr_req(wr_req), .wr_data(wr_data), .rd_req(rd_req), .replay_req(replay_req), .busy(),
    .wr_done(), .wr_refused(), .rd_valid(), .rd_data(), .rd_refused(),
    .replay_refused(dp_replay_refused), .flags_valid(), .half_level(),
    .dev_flags(dp_dev_flags), .dev_ctrl(dp_dev_ctrl), .chain_in_n(dp_chain_in_n),
    .first_chain_select_n(), .dev_din(dp_dev_din), .dev_dout(dp_dev_dout));
  afx_fifo_model #(.DEPTH_P(DEPTH)) u_afx_fifo_model_depth (.ctrl(dp_dev_ctrl),
    .chain_in_n(dp_chain_in_n), .din(dp_dev_din), .dout(dp_dev_dout), .flags(dp_dev_flags));
  // Sticky record of replay refusals: depth host, single host
  always @(posedge clk) if (!rst) rpl_ref <= rpl_ref | {dp_replay_refused, replay_refused};
  afx_fifo_model #(.DEPTH_P(DEPTH)) u_afx_fifo_model (.ctrl(dev_ctrl), .chain_in_n(chain_in_n),
    .din(dev_din), .dout(dev_dout), .flags(dev_flags));
  always #5 clk = ~clk;
  task automatic wait_idle();
    int n = 0;
    do begin @(posedge clk); #1; n++; end
    while (!(busy === 1'b0 && flags_valid === 1'b1) && n < 100);
    `CHK("host idle", 1'b1, busy === 1'b0 && flags_valid === 1'b1)
  endtask
  // k: init, replay, write, read; seen: done, wr refused, valid, rd refused
  task automatic req(input logic [3:0] k, input logic [DATA_W-1:0] d);
    wait_idle();
    @(posedge clk);
    {init_req, replay_req, wr_req, rd_req} <= k;
    wr_data <= d;
    @(posedge clk);
    {init_req, replay_req, wr_req, rd_req} <= 4'h0;
    seen = 4'h0;
    repeat (8) begin #1; seen |= {wr_done, wr_refused, rd_valid, rd_refused}; @(posedge clk); end
    #1;
  endtask
  task automatic sc_empty_read();
    req(4'h1, 9'h000);
    `CHK("read on empty", 4'h1, seen)
  endtask
  task automatic sc_fill_drain();
    for (int i = 0; i < DEPTH; i++) begin
      req(4'h2, 9'h150 + 9'(i));
      `CHK("write", 4'h8, seen)
    end
    wait_idle();
    `CHK("half set", 1'b1, half_level)
    req(4'h2, 9'h0FF);
    `CHK("write on full", 4'h4, seen)
    for (int i = 0; i < DEPTH; i++) begin
      req(4'h1, 9'h000);
      `CHK("read", {4'h2, 9'h150 + 9'(i)}, {seen, rd_data})
    end
    wait_idle();
    `CHK("half clear", 1'b0, half_level)
  endtask
  task automatic sc_wrap();
    for (int i = 0; i < 3; i++) begin
      req(4'h2, 9'h1E0 - 9'(i));
      req(4'h1, 9'h000);
      `CHK("wrap read", {4'h2, 9'h1E0 - 9'(i)}, {seen, rd_data})
    end
  endtask
  task automatic sc_replay();
    req(4'h8, 9'h000);
    req(4'h2, 9'h011);
    req(4'h2, 9'h122);
    for (int p = 0; p < 2; p++) begin
      req(4'h1, 9'h000);
      `CHK("first word", 9'h011, rd_data)
      req(4'h1, 9'h000);
      `CHK("second word", 9'h122, rd_data)
      if (p == 0) req(4'h4, 9'h000);
    end
    req(4'h1, 9'h000);
    `CHK("replay keeps writes", 4'h1, seen)
    `CHK("replay refusals", 2'b10, rpl_ref)
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sc_empty_read();
    sc_fill_drain();
    sc_wrap();
    sc_replay();
    stop_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
